/* irqc_params.svh */
/*
 * Constants of the priority interrupt controller: widths, codes, reset address.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef IRQC_PARAMS_SVH
`define IRQC_PARAMS_SVH
// ****************************************
// Widths
// ****************************************
`define IRQC_NSRC 82
`define IRQC_VNW 7
`define IRQC_VBW 14
`define IRQC_AW 21
`define IRQC_FALW 16
`define IRQC_FAHW 5
`define IRQC_SYNC_N 3
// ****************************************
// Codes and reset values
// ****************************************
`define IRQC_PRI_OFF 2'h0
`define IRQC_FAST_LVL 2'h2
`define IRQC_TOP_LVL 2'h3
`define IRQC_LC_NONE 2'h0
`define IRQC_LC_L0 2'h1
`define IRQC_LC_L1 2'h2
`define IRQC_LC_L23 2'h3
`define IRQC_RST_ADDR 21'h0_0000
`define IRQC_SYNC_RST 3'h7
`endif

/* irqc_pkg.sv */
/*
 * Types of the priority interrupt controller.
 * Assumes irqc_params.svh is on the include path.
 */
`default_nettype none
`include "irqc_params.svh"
package irqc_pkg;
    // ****************************************
    // Operating mode and fast channel
    // ****************************************
    typedef enum logic [1:0] {
        IRQC_RUN = 2'h1,
        IRQC_LOWPWR = 2'h2
    } irqc_mode_e;
    typedef struct packed {
        logic [`IRQC_VNW-1:0] match;
        logic [`IRQC_FAHW-1:0] addr_hi;
        logic [`IRQC_FALW-1:0] addr_lo;
    } irqc_fast_s;
    // ****************************************
    // Whole state of the controller
    // ****************************************
    typedef struct packed {
        irqc_mode_e mode;
        logic boot;
        logic pend;
        logic fast;
        logic [1:0] lvl_code;
        logic [`IRQC_VNW-1:0] vnum;
        logic [`IRQC_AW-1:0] addr;
        logic [`IRQC_NSRC-1:0] wake_en;
        logic [`IRQC_SYNC_N-1:0] sync_a;
        logic [`IRQC_SYNC_N-1:0] sync_b;
        logic [1:0] lvl_pin;
        logic [1:0] edge_pend;
    } irqc_state_s;
endpackage
`default_nettype wire

/* irqc_arbiter_unit.sv */
/*
 * Priority interrupt controller: arbitration, vector forming, fast
 * channels, low-power wakeup and reset fetch address.
 * Assumes request inputs come from logic on clk_in, the two external pins
 * are asynchronous and active low, and all configuration but the FIXED_HI_MASK, EXT_A_SRC and EXT_B_SRC parameters arrives on ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irqc_params.svh"
module irqc_arbiter_unit #(
    parameter logic [`IRQC_NSRC-1:0] FIXED_HI_MASK = '0,
    parameter logic [`IRQC_VNW-1:0] EXT_A_SRC = 7'h02,
    parameter logic [`IRQC_VNW-1:0] EXT_B_SRC = 7'h03
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Requests and their priority codes
    input wire logic [`IRQC_NSRC-1:0] irq_req_in,
    input wire logic [`IRQC_NSRC-1:0][1:0] priority_level_regs_in,
    // Vector base and fast channels
    input wire logic [`IRQC_VBW-1:0] vector_base_reg_in,
    input wire irqc_pkg::irqc_fast_s [1:0] fast_chan_in,
    // Core side
    input wire logic [1:0] core_status_mask_in,
    input wire logic fetch_done_in,
    // Low power and external pins
    input wire logic lowpwr_in,
    input wire logic stop_in,
    input wire logic can_wake_in,
    input wire logic ext_irq_pin_a_n_in,
    input wire logic ext_irq_pin_b_n_in,
    input wire logic [1:0] ext_edge_cfg_in,
    input wire logic [1:0] ext_clr_in,
    // Outputs to the core and the system integration unit
    output logic irq_pending_out,
    output logic fast_hit_out,
    output logic [`IRQC_VNW-1:0] vec_num_out,
    output logic [`IRQC_AW-1:0] vec_addr_out,
    output logic [1:0] current_level_code_out,
    output logic wake_out
);
    // ****************************************
    // Decode helpers
    // ****************************************
    // Priority code to level; fixed sources skip level 0
    function automatic logic [1:0] code_to_lvl(input logic [1:0] code, input logic hi);
        code_to_lvl = hi ? code : code - 2'h1;
    endfunction

    // Level of the winner to the two-bit code for the core
    function automatic logic [1:0] lvl_to_code(input logic found, input logic [1:0] lvl);
        if (!found) begin
            lvl_to_code = `IRQC_LC_NONE;
        end else if (lvl == 2'h0) begin
            lvl_to_code = `IRQC_LC_L0;
        end else if (lvl == 2'h1) begin
            lvl_to_code = `IRQC_LC_L1;
        end else begin
            lvl_to_code = `IRQC_LC_L23;
        end
    endfunction

    irqc_pkg::irqc_state_s st_q;
    irqc_pkg::irqc_state_s st_d;
    logic [`IRQC_NSRC-1:0] req_eff;
    logic [`IRQC_NSRC-1:0] enabled;
    logic [`IRQC_NSRC-1:0][1:0] lvl;
    logic sel_found;
    logic [1:0] sel_lvl;
    logic [`IRQC_VNW-1:0] sel_idx;
    logic [1:0] fast_match;
    logic [1:0] ext_act;

    // ****************************************
    // External pins: edge or level per mode
    // ****************************************
    // Asleep there is no clock to see an edge, so level wins
    assign ext_act[0] = (ext_edge_cfg_in[0] && st_q.mode == irqc_pkg::IRQC_RUN) ?
                        st_q.edge_pend[0] : !st_q.lvl_pin[0];
    assign ext_act[1] = (ext_edge_cfg_in[1] && st_q.mode == irqc_pkg::IRQC_RUN) ?
                        st_q.edge_pend[1] : !st_q.lvl_pin[1];

    // Per-source level and qualified request
    genvar gi;
    generate
        for (gi = 0; gi < `IRQC_NSRC; gi++) begin : g_src
            logic raw;
            assign raw = (gi == EXT_A_SRC) ? ext_act[0] :
                         (gi == EXT_B_SRC) ? ext_act[1] : irq_req_in[gi];
            assign enabled[gi] = priority_level_regs_in[gi] != `IRQC_PRI_OFF;
            assign lvl[gi] = code_to_lvl(priority_level_regs_in[gi], FIXED_HI_MASK[gi]);
            assign req_eff[gi] = raw && enabled[gi];
        end
    endgenerate

    // ****************************************
    // Arbitration
    // ****************************************
    // Highest permitted level first, then lowest source number
    always_comb begin
        sel_found = 1'b0;
        sel_lvl = 2'h0;
        sel_idx = '0;
        for (int l = 3; l >= 0; l--) begin
            if (!sel_found && 2'(l) >= core_status_mask_in) begin
                for (int i = `IRQC_NSRC - 1; i >= 0; i--) begin
                    if (req_eff[i] && lvl[i] == 2'(l)) begin
                        sel_found = 1'b1;
                        sel_lvl = 2'(l);
                        sel_idx = 7'(i);
                    end
                end
            end
        end
    end

    // Fast channel compare on the live winner, ahead of the core
    assign fast_match[0] = fast_chan_in[0].match == sel_idx;
    assign fast_match[1] = fast_chan_in[1].match == sel_idx;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        // Three-flop pin synchronisers; a change counts when flops 2 and 3 agree
        st_d.sync_a = {st_q.sync_a[1:0], ext_irq_pin_a_n_in};
        st_d.sync_b = {st_q.sync_b[1:0], ext_irq_pin_b_n_in};
        if (st_q.sync_a[1] == st_q.sync_a[2]) begin
            st_d.lvl_pin[0] = st_q.sync_a[2];
        end
        if (st_q.sync_b[1] == st_q.sync_b[2]) begin
            st_d.lvl_pin[1] = st_q.sync_b[2];
        end
        // Falling edge latch; a new edge beats a clear in the same cycle
        for (int p = 0; p < 2; p++) begin
            if (ext_clr_in[p]) begin
                st_d.edge_pend[p] = 1'b0;
            end
            if (st_q.lvl_pin[p] && !st_d.lvl_pin[p]) begin
                st_d.edge_pend[p] = 1'b1;
            end
        end
        // Mode; the wake set is frozen on entry to low power
        case (st_q.mode)
            irqc_pkg::IRQC_RUN: begin
                if (lowpwr_in) begin
                    st_d.mode = irqc_pkg::IRQC_LOWPWR;
                    st_d.wake_en = enabled;
                end
            end
            irqc_pkg::IRQC_LOWPWR: begin
                if (!lowpwr_in) begin
                    st_d.mode = irqc_pkg::IRQC_RUN;
                end
            end
            default: begin
                st_d.mode = irqc_pkg::IRQC_RUN;
            end
        endcase
        // Boot fetch address holds until the core has taken it
        if (fetch_done_in) begin
            st_d.boot = 1'b0;
        end
        if (st_q.boot) begin
            st_d.pend = 1'b0;
            st_d.fast = 1'b0;
            st_d.lvl_code = `IRQC_LC_NONE;
            st_d.vnum = '0;
            st_d.addr = `IRQC_RST_ADDR;
        end else begin
            st_d.pend = sel_found;
            st_d.lvl_code = lvl_to_code(sel_found, sel_lvl);
            st_d.vnum = sel_idx;
            st_d.fast = sel_found && sel_lvl == `IRQC_FAST_LVL && (|fast_match);
            if (st_d.fast && fast_match[0]) begin
                st_d.addr = {fast_chan_in[0].addr_hi, fast_chan_in[0].addr_lo};
            end else if (st_d.fast) begin
                st_d.addr = {fast_chan_in[1].addr_hi, fast_chan_in[1].addr_lo};
            end else begin
                st_d.addr = {vector_base_reg_in, sel_idx};
            end
        end
    end

    // State register; the enable freezes everything
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q.mode <= irqc_pkg::IRQC_RUN;
            st_q.boot <= 1'b1;
            st_q.pend <= 1'b0;
            st_q.fast <= 1'b0;
            st_q.lvl_code <= `IRQC_LC_NONE;
            st_q.vnum <= '0;
            st_q.addr <= `IRQC_RST_ADDR;
            st_q.wake_en <= '0;
            st_q.sync_a <= `IRQC_SYNC_RST;
            st_q.sync_b <= `IRQC_SYNC_RST;
            st_q.lvl_pin <= 2'h3;
            st_q.edge_pend <= 2'h0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign irq_pending_out = st_q.pend;
    assign fast_hit_out = st_q.fast;
    assign vec_num_out = st_q.vnum;
    assign vec_addr_out = st_q.addr;
    assign current_level_code_out = st_q.lvl_code;
    // Wake is combinational because the clock is stopped; stop admits only
    // clock-free sources, the raw pins are read as plain low levels
    assign wake_out = (st_q.mode == irqc_pkg::IRQC_LOWPWR) &&
                      (stop_in ? (can_wake_in || !ext_irq_pin_a_n_in || !ext_irq_pin_b_n_in)
                               : |(req_eff & st_q.wake_en));

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_BOOT_ADDR: assert property (st_q.boot |-> vec_addr_out == `IRQC_RST_ADDR && !irq_pending_out)
        else $error("boot address not held");
    AST_MASK: assert property (sel_found |-> sel_lvl >= core_status_mask_in)
        else $error("masked level selected");
    AST_DISABLED: assert property (sel_found |-> priority_level_regs_in[sel_idx] != `IRQC_PRI_OFF)
        else $error("disabled source selected");
    AST_VNUM: assert property (ce_in && !st_q.boot && sel_found |=> irq_pending_out && vec_num_out == $past(sel_idx))
        else $error("winner not presented");
    AST_NORMAL: assert property (ce_in && !st_q.boot && sel_found && fast_match == 2'h0 |=>
        vec_addr_out == {$past(vector_base_reg_in), $past(sel_idx)} && !fast_hit_out)
        else $error("normal vector wrong");
    AST_FAST: assert property (ce_in && !st_q.boot && sel_found && sel_lvl == `IRQC_FAST_LVL && fast_match[0] |=>
        fast_hit_out && vec_addr_out == {$past(fast_chan_in[0].addr_hi), $past(fast_chan_in[0].addr_lo)})
        else $error("fast vector wrong");
    AST_CODE: assert property (irq_pending_out == (current_level_code_out != `IRQC_LC_NONE))
        else $error("level code and pending disagree");
    AST_WAKE_FROZEN: assert property (st_q.mode == irqc_pkg::IRQC_LOWPWR &&
        $past(st_q.mode) == irqc_pkg::IRQC_LOWPWR |-> $stable(st_q.wake_en))
        else $error("wake set changed while asleep");
    AST_NO_WAKE_RUN: assert property (st_q.mode == irqc_pkg::IRQC_RUN |-> !wake_out)
        else $error("wake while running");
    AST_EXT_LEVEL: assert property (st_q.mode == irqc_pkg::IRQC_LOWPWR && !st_q.lvl_pin[0] |-> ext_act[0])
        else $error("pin a not level sensitive asleep");

    COV_FAST: cover property (fast_hit_out);
    COV_NESTED: cover property (irq_pending_out && current_level_code_out == `IRQC_LC_L23);
    COV_WAKE: cover property (wake_out && !stop_in);
    COV_STOP_WAKE: cover property (wake_out && stop_in);
endmodule
`default_nettype wire

/* irqc_core_model.sv */
/*
 * Behavioural model of the processor core beside the interrupt controller.
 * Assumes one clock, asynchronous active-high reset, controller outputs registered.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irqc_params.svh"
module irqc_core_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // From the controller
    input wire logic irq_pending_in,
    input wire logic fast_hit_in,
    input wire logic [`IRQC_AW-1:0] vec_addr_in,
    // To the controller and the bench
    output logic fetch_done_out,
    output logic fast_entry_out
);
    logic [2:0] boot_cnt_q;
    // Boot fetch lasts a few cycles, so reset address is seen first
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            boot_cnt_q <= 3'h0;
        end else if (boot_cnt_q != 3'h4) begin
            boot_cnt_q <= boot_cnt_q + 3'h1;
        end
    end
    assign fetch_done_out = (boot_cnt_q == 3'h4);
    // Opcode stand-in: low address bits both set means subroutine jump
    assign fast_entry_out = irq_pending_in & fast_hit_in & (vec_addr_in[1:0] != 2'h3);
endmodule
`default_nettype wire

/* test_irqc_arbiter_unit.sv */
/*
 * Self-checking bench of the interrupt controller with a reference model.
 * Assumes irqc_params.svh on the include path and the core model compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irqc_params.svh"
module test_irqc_arbiter_unit;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic lp = 1'b0;
    logic stp = 1'b0;
    logic canw = 1'b0;
    logic pa = 1'b1;
    logic [1:0] edg = 2'h0;
    logic ce = 1'b1;
    logic [1:0] clr = 2'h0;
    logic [1:0] mask = 2'h0;
    logic [13:0] base = 14'h0000;
    logic [81:0] req = '0;
    logic [81:0][1:0] pri = '0;
    irqc_pkg::irqc_fast_s [1:0] fc = '0;
    logic fd, pend, fh, wk, ep, ef, fe;
    logic [1:0] code, ec;
    logic [6:0] vn, ev;
    logic [20:0] va, ea;
    int n_fail = 0;
    int comparisons = 0;
    int unsigned seed = 6;

    irqc_arbiter_unit u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .irq_req_in(req), .priority_level_regs_in(pri), .vector_base_reg_in(base),
        .fast_chan_in(fc), .core_status_mask_in(mask), .fetch_done_in(fd),
        .lowpwr_in(lp), .stop_in(stp), .can_wake_in(canw), .ext_irq_pin_a_n_in(pa),
        .ext_irq_pin_b_n_in(1'b1), .ext_edge_cfg_in(edg), .ext_clr_in(clr),
        .irq_pending_out(pend), .fast_hit_out(fh), .vec_num_out(vn),
        .vec_addr_out(va), .current_level_code_out(code), .wake_out(wk));
    irqc_core_model u_core (.clk_in(clk_in), .rst_in(rst_in), .irq_pending_in(pend),
        .fast_hit_in(fh), .vec_addr_in(va), .fetch_done_out(fd), .fast_entry_out(fe));

    // Free-running 20 MHz clock
    always #25 clk_in = ~clk_in;

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Inputs always change 2 ns after the rising edge
    task automatic tick();
        @(posedge clk_in);
        #2;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // Reference: highest permitted level wins, lowest index within it
    task automatic model();
        int bl;
        int bi;
        int lv;
        bl = -1;
        bi = 0;
        for (int i = 0; i < `IRQC_NSRC; i++) begin
            lv = int'(pri[i]) - 1;
            // Sources 2 and 3 follow the pins, held inactive here
            if (i != 2 && i != 3 && req[i] && pri[i] != 2'h0 && lv >= int'(mask) && lv > bl) begin
                bl = lv;
                bi = i;
            end
        end
        ep = (bl >= 0);
        ec = (bl < 0) ? 2'h0 : 2'(bl + 1);
        ev = 7'(bi);
        ef = (bl == 2) && (fc[0].match == ev || fc[1].match == ev);
        ea = {base, ev};
        if (ef) begin
            ea = (fc[0].match == ev) ? {fc[0].addr_hi, fc[0].addr_lo} : {fc[1].addr_hi, fc[1].addr_lo};
        end
    endtask

    task automatic cmp();
        model();
        chk(pend === ep, "pending differs");
        chk(code === ec, "level code differs");
        if (ep) begin
            chk(vn === ev, "vector number differs");
            chk(va === ea, "vector address differs");
            chk(fh === ef, "fast hit differs");
        end
        chk(fe === (ef && ea[1:0] != 2'h3), "fast entry differs");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #(5000 * 50);
        n_fail++;
        results();
    end

    // Main sequence
    initial begin
        repeat (20) tick();
        rst_in = 1'b0;
        pri[5] = 2'h1;
        req[5] = 1'b1;
        repeat (2) begin
            tick();
            chk(va === 21'h0_0000 && pend === 1'b0, "boot address lost");
        end
        repeat (5) tick();
        cmp();
        $display("test boot done");
        // Tie within one level: source 0 beats 81, then 81 alone
        req = '0;
        pri = '0;
        pri[0] = 2'h1;
        pri[81] = 2'h1;
        req[0] = 1'b1;
        req[81] = 1'b1;
        tick();
        cmp();
        req[0] = 1'b0;
        tick();
        cmp();
        // Enable low freezes the presented winner
        ce = 1'b0;
        req[0] = 1'b1;
        tick();
        chk(vn === 7'h51 && pend === 1'b1, "state moved while disabled");
        ce = 1'b1;
        tick();
        cmp();
        $display("test tie done");
        // Random mixes of requests, codes, masks and fast channels
        for (int k = 0; k < 400; k++) begin
            req = 82'({rnd(), rnd(), rnd()});
            for (int i = 0; i < `IRQC_NSRC; i++) begin
                pri[i] = 2'(rnd());
            end
            mask = 2'(rnd());
            base = 14'(rnd());
            fc = 56'({rnd(), rnd()});
            fc[0].match = 7'(rnd() % 8);
            fc[1].match = 7'(rnd() % 8);
            tick();
            cmp();
        end
        $display("test random done");
        // Wait mode: only sources enabled at entry may wake
        req = '0;
        pri = '0;
        mask = 2'h0;
        pri[10] = 2'h1;
        lp = 1'b1;
        repeat (3) tick();
        pri[20] = 2'h1;
        req[20] = 1'b1;
        #1 chk(wk === 1'b0, "late enable woke");
        tick();
        req[10] = 1'b1;
        #1 chk(wk === 1'b1, "no wake in wait");
        tick();
        stp = 1'b1;
        #1 chk(wk === 1'b0, "peripheral woke stop");
        tick();
        canw = 1'b1;
        #1 chk(wk === 1'b1, "no wake from CAN");
        tick();
        canw = 1'b0;
        edg = 2'h3;
        pa = 1'b0;
        #1 chk(wk === 1'b1, "pin did not wake stop");
        tick();
        // Edge-configured pin a still counts as a level while asleep
        stp = 1'b0;
        pri[2] = 2'h1;
        repeat (5) tick();
        chk(pend === 1'b1 && vn === 7'h02, "pin level ignored asleep");
        // Back in run with the latch cleared, a held-low pin is no edge
        lp = 1'b0;
        clr = 2'h1;
        tick();
        clr = 2'h0;
        tick();
        chk(pend === 1'b1 && vn === 7'h0A, "held pin seen as edge");
        $display("test lowpower done");
        // Mid-run reset: boot address again until the core has fetched
        pa = 1'b1;
        edg = 2'h0;
        pri[2] = 2'h0;
        rst_in = 1'b1;
        repeat (2) tick();
        rst_in = 1'b0;
        tick();
        chk(va === `IRQC_RST_ADDR && pend === 1'b0, "boot address lost after reset");
        repeat (6) tick();
        cmp();
        $display("test reset done");
        results();
    end
endmodule
`default_nettype wire
